// ===== dv/cpu_interrupt_source_selector_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_source_selector_tb import csel_pkg::*; ;
  // ****
  // signals
  // ****
  localparam int lsb [6] = '{0, 5, 10, 16, 21, 26};
  localparam int dflt [12] = '{4, 5, 6, 7, 8, 9, 3, 10, 11, 0, 1, 2};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] src = '0;
  logic [3:0] pins = '0;
  logic [1:0] fixed_ev = '0;
  logic awready, wready, bvalid, arready, rvalid, cpu_int_any, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] cpu_int;
  logic [3:0] cpu_int_top, serve;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 aclk = ~aclk;

  csel_top u_dut (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .reset_event(fixed_ev[0]), .nmi_event(fixed_ev[1]), .host_to_cpu_irq(src[0]), .timer_zero_irq(src[1]),
    .timer_one_irq(src[2]), .mem_a_refresh_timer_irq(src[3]), .pin_event_four(src[4]), .pin_event_five(src[5]),
    .pin_event_six(src[6]), .pin_event_seven(src[7]), .dma_completion_irq(src[8]),
    .emulation_dma_event(src[9]), .emulation_exchange_rx(src[10]), .emulation_exchange_tx(src[11]),
    .serial0_tx_irq(src[12]), .serial0_rx_irq(src[13]), .serial1_tx_irq(src[14]), .serial1_rx_irq(src[15]),
    .pin_event_zero(src[16]), .serial2_tx_irq(src[17]), .serial2_rx_irq(src[18]), .timer_two_irq(src[19]),
    .mem_b_refresh_timer_irq(src[20]), .cell_interface_irq(src[23]), .viterbi_coproc_irq(src[30]),
    .turbo_coproc_irq(src[31]), .pin_interrupt_input(pins), .cpu_int, .cpu_int_top, .cpu_int_any, .irq
  );

  csel_core_model u_core (.aclk, .aresetn, .cpu_int, .serve);

  // ****
  // helpers
  // ****
  task automatic complete_run();
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic ok(input int c);
    return !(c == 21 || c == 22 || (c >= 24 && c <= 29));
  endfunction

  // every field but one parked on a reserved code, so only one line can fire
  function automatic logic [31:0] fill(input int pos, input logic [4:0] c);
    logic [31:0] v;
    v = '0;
    for (int k = 0; k < 6; k++) v[lsb[k] +: 5] = (k == pos) ? c : 5'h15;
    return v;
  endfunction

  task automatic wr(input logic [31:0] a, input logic [31:0] dt, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] dt, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    dt = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // hang guard, ceiling well above the few hundred cycles the tests need
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      complete_run();
    end
  end

  // ****
  // tests
  // ****
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int l;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CSEL_ADDR_HIGH, d, r);
    chk(d, 32'h08202d43);
    rd(CSEL_ADDR_LOW, d, r);
    chk(d, 32'h250718a4);
    for (int i = 0; i < 16; i++) begin
      l = (i < 4) ? i : i - 4;
      if (i < 4)
        pins <= 4'h1 << i;
      else
        src <= 32'h1 << dflt[l];
      repeat (5) @(posedge aclk);
      chk(cpu_int, 32'h10 << l);
      chk(cpu_int_top, 32'(l + 4));
      pins <= 4'h0;
      src <= '0;
      repeat (5) @(posedge aclk);
    end
    for (int c = 0; c < 32; c++) begin
      l = c % 12;
      wr(CSEL_ADDR_LOW, fill(l, 5'(c)), r);
      wr(CSEL_ADDR_HIGH, fill(l - 6, 5'(c)), r);
      src <= ok(c) ? 32'h1 << c : 32'hffffffff;
      repeat (3) @(posedge aclk);
      chk(cpu_int, ok(c) ? 32'h10 << l : 32'h0);
      chk(cpu_int_any, 32'(ok(c)));
      src <= '0;
      @(posedge aclk);
    end
    fixed_ev <= 2'b11;
    src <= 32'h80000000;
    repeat (3) @(posedge aclk);
    chk(cpu_int, 32'h0803);
    chk(serve, 32'h0);
    fixed_ev <= 2'b10;
    repeat (3) @(posedge aclk);
    chk(cpu_int_top, 32'h1);
    fixed_ev <= 2'b00;
    repeat (3) @(posedge aclk);
    chk(serve, 32'hb);
    src <= '0;
    repeat (3) @(posedge aclk);
    rd(CSEL_ADDR_STATUS, d, r);
    wr(CSEL_ADDR_MASK, 32'h0800, r);
    src <= 32'h80000000;
    repeat (3) @(posedge aclk);
    chk(irq, 32'h1);
    rd(CSEL_ADDR_STATUS, d, r);
    chk(d, 32'h0800);
    repeat (2) @(posedge aclk);
    chk(irq, 32'h0);
    wr(CSEL_ADDR_MASK, 32'h0, r);
    src <= '0;
    repeat (3) @(posedge aclk);
    src <= 32'h80000000;
    repeat (3) @(posedge aclk);
    chk(irq, 32'h0);
    rd(CSEL_ADDR_STATUS, d, r);
    chk(d, 32'h0800);
    wr(CSEL_ADDR_LOW, 32'hffffffff, r);
    rd(CSEL_ADDR_LOW, d, r);
    chk(d, 32'h7fff7fff);
    rd(32'h019c0010, d, r);
    chk(r, 32'h2);
    chk(d, 32'h0);
    wr(32'h019c0010, 32'h1, r);
    chk(r, 32'h2);
    complete_run();
  end
endmodule
`default_nettype wire

// ===== dv/csel_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// core side: latches the line it would service next
// ****
module csel_core_model import csel_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] cpu_int,
  output logic [3:0] serve
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serve <= 4'h0;
    end else begin
      serve <= 4'h0;
      // scan downwards so the lowest active line is the last to land
      for (int i = 15; i >= 0; i--) begin
        if (cpu_int[i]) begin
          serve <= 4'(i);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/csel_pkg.sv
package csel_pkg;

  // ********************************
  // register map
  // ********************************
  localparam logic [31:0] CSEL_ADDR_HIGH = 32'h019c0000;
  localparam logic [31:0] CSEL_ADDR_LOW = 32'h019c0004;
  localparam logic [31:0] CSEL_ADDR_STATUS = 32'h019c0008;
  localparam logic [31:0] CSEL_ADDR_MASK = 32'h019c000c;

  // ********************************
  // selector fields and reset values
  // ********************************
  localparam int CSEL_CODE_W = 5;
  localparam int CSEL_NUM_SEL = 12;
  localparam int CSEL_FLD_PER_REG = 6;
  localparam int CSEL_FLD_LSB [CSEL_FLD_PER_REG] = '{0, 5, 10, 16, 21, 26};
  localparam logic [31:0] CSEL_SEL_WMASK = 32'h7fff7fff;
  localparam logic [31:0] CSEL_HIGH_RESET = 32'h08202d43;
  localparam logic [31:0] CSEL_LOW_RESET = 32'h250718a4;
  localparam logic [15:0] CSEL_MASK_RESET = 16'h0000;
  localparam logic [15:0] CSEL_STATUS_RESET = 16'h0000;
  localparam logic [1:0] CSEL_RESP_OKAY = 2'b00;
  localparam logic [1:0] CSEL_RESP_SLVERR = 2'b10;
  localparam int CSEL_SYNC_STAGES = 2;

  function automatic logic [4:0] csel_field(input logic [31:0] sel, input int idx);
    return sel[CSEL_FLD_LSB[idx] +: CSEL_CODE_W];
  endfunction

  // reserved codes: 10101, 10110, 11000..11101
  function automatic logic csel_code_ok(input logic [4:0] code);
    return !(code == 5'h15 || code == 5'h16 || (code >= 5'h18 && code <= 5'h1d));
  endfunction

  function automatic logic csel_hit(input logic [31:0] a, input logic [31:0] base);
    return a[31:2] == base[31:2];
  endfunction

endpackage

// ===== rtl/csel_route.sv
`timescale 1ns/1ps
`default_nettype none
module csel_route import csel_pkg::*; (
  input wire logic [31:0] sel_low,
  input wire logic [31:0] sel_high,
  input wire logic [31:0] src,
  output logic [CSEL_NUM_SEL-1:0] line_req
);

  // ********************************
  // per-line source selection
  // ********************************
  always_comb begin
    logic [4:0] code;
    code = 5'h00;
    line_req = '0;
    for (int i = 0; i < CSEL_NUM_SEL; i++) begin
      if (i < CSEL_FLD_PER_REG) begin
        code = csel_field(sel_low, i);
      end else begin
        code = csel_field(sel_high, i - CSEL_FLD_PER_REG);
      end
      // reserved codes never reach the core
      line_req[i] = csel_code_ok(code) && src[code];
    end
  end

endmodule
`default_nettype wire

// ===== rtl/csel_sync.sv
`timescale 1ns/1ps
`default_nettype none
module csel_sync import csel_pkg::*; #(
  parameter int W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } csel_sync_s;

  csel_sync_s r;
  csel_sync_s next_r;

  // first stage feeds only the second
  always_comb begin
    next_r = r;
    next_r.meta = d;
    next_r.stable = r.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.stable;

endmodule
`default_nettype wire

// ===== rtl/csel_top.sv
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Lines 0 to 3 are fixed: 0 is reset, 1 is the non-maskable event, 2 and 3 never assert.
// - Each of lines 4 to 15 follows the source named by its own 5-bit selector field.
// - The low selector holds fields for lines 4..9 at 4:0, 9:5, 14:10, 20:16, 25:21, 30:26.
// - The high selector holds fields for lines 10..15 with the same layout.
// - After reset lines 4..9 select codes 4, 5, 6, 7, 8 and 9.
// - After reset lines 10..15 select codes 3, 10, 11, 0, 1 and 2.
// - Codes 12 to 20 map to serial 0/1 tx/rx, pin event 0, serial 2 tx/rx, timer 2, memory B refresh.
// - Code 23 is the cell interface, 30 Viterbi, 31 turbo; the other high codes are reserved.
// - Pins four to seven act as synchronised interrupt inputs feeding codes 4 to 7.
// - Line 0 has the highest priority and line 15 the lowest.
// - The high selector sits at 0x019c0000 and the low one at 0x019c0004.
module csel_top import csel_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic reset_event,
  input wire logic nmi_event,
  input wire logic host_to_cpu_irq,
  input wire logic timer_zero_irq,
  input wire logic timer_one_irq,
  input wire logic timer_two_irq,
  input wire logic mem_a_refresh_timer_irq,
  input wire logic mem_b_refresh_timer_irq,
  input wire logic pin_event_zero,
  input wire logic pin_event_four,
  input wire logic pin_event_five,
  input wire logic pin_event_six,
  input wire logic pin_event_seven,
  input wire logic [3:0] pin_interrupt_input,
  input wire logic dma_completion_irq,
  input wire logic emulation_dma_event,
  input wire logic emulation_exchange_rx,
  input wire logic emulation_exchange_tx,
  input wire logic serial0_tx_irq,
  input wire logic serial0_rx_irq,
  input wire logic serial1_tx_irq,
  input wire logic serial1_rx_irq,
  input wire logic serial2_tx_irq,
  input wire logic serial2_rx_irq,
  input wire logic cell_interface_irq,
  input wire logic viterbi_coproc_irq,
  input wire logic turbo_coproc_irq,
  output logic [15:0] cpu_int,
  output logic [3:0] cpu_int_top,
  output logic cpu_int_any,
  output logic irq
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_ok;
    logic [31:0] aw_addr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] sel_high;
    logic [31:0] sel_low;
    logic [15:0] status;
    logic [15:0] mask;
    logic [15:0] lines;
    logic [3:0] top;
    logic any;
    logic irq;
  } csel_state_s;

  csel_state_s r;
  csel_state_s next_r;
  logic [3:0] pin_sync;
  logic [31:0] src;
  logic [CSEL_NUM_SEL-1:0] line_req;

  // ********************************
  // helpers
  // ********************************
  function automatic logic [31:0] csel_wr(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb, input logic [31:0] keep);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        v[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return v & keep;
  endfunction

  // lowest index wins, so line 0 outranks everything
  function automatic logic [3:0] csel_prio(input logic [15:0] v);
    logic [3:0] t;
    t = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        t = 4'(i);
      end
    end
    return t;
  endfunction

  // ********************************
  // event sources
  // ********************************
  // pins come from outside the clock domain
  csel_sync #(.W(4)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(pin_interrupt_input),
    .q(pin_sync)
  );

  // bit index is the selector code
  assign src = {turbo_coproc_irq, viterbi_coproc_irq, 6'h00, cell_interface_irq, 2'b00,
                mem_b_refresh_timer_irq, timer_two_irq, serial2_rx_irq, serial2_tx_irq,
                pin_event_zero, serial1_rx_irq, serial1_tx_irq, serial0_rx_irq, serial0_tx_irq,
                emulation_exchange_tx, emulation_exchange_rx, emulation_dma_event, dma_completion_irq,
                pin_event_seven | pin_sync[3], pin_event_six | pin_sync[2],
                pin_event_five | pin_sync[1], pin_event_four | pin_sync[0],
                mem_a_refresh_timer_irq, timer_one_irq, timer_zero_irq, host_to_cpu_irq};

  csel_route u_route (
    .sel_low(r.sel_low),
    .sel_high(r.sel_high),
    .src(src),
    .line_req(line_req)
  );

  // ********************************
  // next state
  // ********************************
  always_comb begin
    logic [15:0] rise;
    logic rd_clr;
    rise = 16'h0000;
    rd_clr = 1'b0;
    next_r = r;
    next_r.lines = {line_req, 2'b00, nmi_event, reset_event};
    rise = next_r.lines & ~r.lines;
    // write channels are taken independently
    if (awvalid && r.awready) begin
      next_r.aw_ok = 1'b1;
      next_r.aw_addr = awaddr;
    end
    if (wvalid && r.wready) begin
      next_r.w_ok = 1'b1;
      next_r.wdata = wdata;
      next_r.wstrb = wstrb;
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end
    if (next_r.aw_ok && next_r.w_ok && !next_r.bvalid) begin
      next_r.aw_ok = 1'b0;
      next_r.w_ok = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = CSEL_RESP_OKAY;
      if (csel_hit(next_r.aw_addr, CSEL_ADDR_HIGH)) begin
        next_r.sel_high = csel_wr(r.sel_high, next_r.wdata, next_r.wstrb, CSEL_SEL_WMASK);
      end else if (csel_hit(next_r.aw_addr, CSEL_ADDR_LOW)) begin
        next_r.sel_low = csel_wr(r.sel_low, next_r.wdata, next_r.wstrb, CSEL_SEL_WMASK);
      end else if (csel_hit(next_r.aw_addr, CSEL_ADDR_MASK)) begin
        next_r.mask = 16'(csel_wr({16'h0000, r.mask}, next_r.wdata, next_r.wstrb, 32'h0000ffff));
      end else if (!csel_hit(next_r.aw_addr, CSEL_ADDR_STATUS)) begin
        next_r.bresp = CSEL_RESP_SLVERR;
      end
    end
    next_r.awready = !next_r.aw_ok;
    next_r.wready = !next_r.w_ok;
    // read channel
    if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end
    if (arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = CSEL_RESP_OKAY;
      next_r.rdata = 32'h00000000;
      if (csel_hit(araddr, CSEL_ADDR_HIGH)) begin
        next_r.rdata = r.sel_high;
      end else if (csel_hit(araddr, CSEL_ADDR_LOW)) begin
        next_r.rdata = r.sel_low;
      end else if (csel_hit(araddr, CSEL_ADDR_STATUS)) begin
        next_r.rdata = {16'h0000, r.status};
        rd_clr = 1'b1;
      end else if (csel_hit(araddr, CSEL_ADDR_MASK)) begin
        next_r.rdata = {16'h0000, r.mask};
      end else begin
        next_r.rresp = CSEL_RESP_SLVERR;
      end
    end
    next_r.arready = !next_r.rvalid;
    // a new edge in the clearing cycle survives the clear
    next_r.status = (rd_clr ? CSEL_STATUS_RESET : r.status) | rise;
    next_r.irq = |(next_r.status & next_r.mask);
    next_r.top = csel_prio(next_r.lines);
    next_r.any = |next_r.lines;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.sel_high <= CSEL_HIGH_RESET;
      r.sel_low <= CSEL_LOW_RESET;
      r.mask <= CSEL_MASK_RESET;
      r.status <= CSEL_STATUS_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign cpu_int = r.lines;
  assign cpu_int_top = r.top;
  assign cpu_int_any = r.any;
  assign irq = r.irq;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_fixed_lines;
    reset_event |=> cpu_int[0] && cpu_int[3:2] == 2'b00;
  endproperty
  a_fixed_lines: assert property (p_fixed_lines) else $error("fixed lines wrong");

  property p_route_four;
    (r.sel_low[4:0] == 5'h04 && pin_event_four) |=> cpu_int[4];
  endproperty
  a_route_four: assert property (p_route_four) else $error("line 4 missed its source");

  property p_low_layout;
    (r.sel_low[20:16] == 5'h07 && pin_event_seven) |=> cpu_int[7];
  endproperty
  a_low_layout: assert property (p_low_layout) else $error("line 7 field misplaced");

  property p_high_layout;
    (r.sel_high[30:26] == 5'h02 && timer_one_irq) |=> cpu_int[15];
  endproperty
  a_high_layout: assert property (p_high_layout) else $error("line 15 field misplaced");

  property p_low_default;
    $past(!aresetn) |-> r.sel_low == CSEL_LOW_RESET;
  endproperty
  a_low_default: assert property (p_low_default) else $error("low selector default wrong");

  property p_high_default;
    $past(!aresetn) |-> r.sel_high == CSEL_HIGH_RESET;
  endproperty
  a_high_default: assert property (p_high_default) else $error("high selector default wrong");

  property p_code_twenty;
    (r.sel_high[14:10] == 5'h14 && mem_b_refresh_timer_irq) |=> cpu_int[12];
  endproperty
  a_code_twenty: assert property (p_code_twenty) else $error("code 20 not routed");

  property p_code_turbo;
    (r.sel_high[9:5] == 5'h1f && turbo_coproc_irq) |=> cpu_int[11];
  endproperty
  a_code_turbo: assert property (p_code_turbo) else $error("code 31 not routed");

  sequence s_pin_held;
    (r.sel_low[4:0] == 5'h04 && $stable(r.sel_low) && pin_interrupt_input[0])[*3];
  endsequence
  property p_pin_path;
    s_pin_held |=> cpu_int[4];
  endproperty
  a_pin_path: assert property (p_pin_path) else $error("pin 4 did not reach line 4");

  property p_priority;
    cpu_int_any |-> cpu_int[cpu_int_top] && (cpu_int & ((16'h0001 << cpu_int_top) - 16'h0001)) == 16'h0000;
  endproperty
  a_priority: assert property (p_priority) else $error("priority index wrong");

  sequence s_read_high;
    arvalid && arready && csel_hit(araddr, CSEL_ADDR_HIGH);
  endsequence
  property p_read_high;
    s_read_high |=> rvalid && rresp == CSEL_RESP_OKAY && rdata == $past(r.sel_high);
  endproperty
  a_read_high: assert property (p_read_high) else $error("high selector read wrong");

  property p_reserved_quiet;
    !csel_code_ok(r.sel_low[9:5]) |=> !cpu_int[5] && r.sel_low[15] == 1'b0 && r.sel_high[31] == 1'b0;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved code or bit leaked");

endmodule
`default_nettype wire
